// >>> rtl/serial_master_defs.svh
// constants for the three-protocol serial master: offsets, fields, resets, timing
`ifndef SERIAL_MASTER_DEFS_SVH
`define SERIAL_MASTER_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_MODE_CONTROL   8'hEB
`define IDX_XFER_STATUS    8'hEC
`define IDX_SHIFT_DATA     8'hCC

// mode/control fields
`define MC_START_BIT       3
`define MC_STOP_BIT        2
`define MC_MODE_HI         1
`define MC_MODE_LO         0

// transfer control/status fields
`define ST_DIR_BIT         3
`define ST_VERIFY_BIT      2
`define ST_NOACK_BIT       1
`define ST_BUSY_BIT        0

// reset values
`define MODE_RST           2'h0
`define BYTE_RST           8'h00
`define WORD_RST           32'h0000_0000
`define CNT_RST            12'h000
`define BIT_RST            4'h0
`define PH_RST             2'h0

// bit positions within a byte transfer
`define LAST_DATA_BIT      4'h7
`define ACK_BIT            4'h8
`define DATA_MSB           7

// timing: system clock 40 MHz, bus clock 62.5 kHz
`define CLK_PERIOD_NS      25
`define SCL_PERIOD_NS      16000
`define SCL_HALF_CYCLES    (`SCL_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define FILTER_LEN         3

`endif

// >>> rtl/serial_master_pkg.sv
// types shared by the serial master files
`default_nettype none
package serial_master_pkg;

  typedef enum logic [1:0] {
    MODE_OFF        = 2'h0,
    MODE_SHIFT      = 2'h1,
    MODE_TWO_WIRE   = 2'h2,
    MODE_THREE_WIRE = 2'h3
  } mode_type;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_LOW   = 5'h04,
    S_HIGH  = 5'h08,
    S_STOP  = 5'h10
  } state_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic serial_frame_enable_pin;
  } line_type;

endpackage
`default_nettype wire

// >>> rtl/sync_glitch_filter.sv
// two-stage synchroniser followed by a majority-free run-length glitch filter
`default_nettype none
module sync_glitch_filter #(
  parameter int unsigned LEN = 3
) (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic din,
  output var  logic dout
);

  logic           meta_r;
  logic           sync_r;
  logic [LEN-1:0] hist_r;
  logic [LEN-1:0] hist_nxt;
  logic           dout_nxt;

  // output only moves once LEN samples agree; idle bus level is high
  always_comb begin
    hist_nxt = {hist_r[LEN-2:0], sync_r};
    dout_nxt = dout;
    if (&hist_r) begin
      dout_nxt = 1'b1;
    end else if (~|hist_r) begin
      dout_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      hist_r <= '1;
      dout   <= 1'b1;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      hist_r <= hist_nxt;
      dout   <= dout_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/tri_protocol_serial_master.sv
// byte-oriented serial master for two-wire, three-wire and shift-register buses
//
// How it works
// - Shift data register cannot be read or written while busy.
// - Mode bits: 00 off, 01 shift register, 10 two-wire, 11 three-wire.
// - Start condition only when start enable and acknowledged protocol both set.
// - Stop condition after the byte when stop enable and acknowledged protocol set.
// - Reset clears mode/control, busy and mode bits; interface starts disabled.
// - Direction bit: one transmits the register, zero receives into it.
// - Verify set at byte start when transmitting in an acknowledged mode, cleared on line mismatch during eight data bits.
// - Verify meaningless otherwise; writing its position sets the vsync interrupt enable.
// - No-ack flag set on missing acknowledge, cleared when busy is next set.
// - Writing one to busy starts one byte unless mode is off; hardware clears busy at the end.
// - One shift register is transmit buffer, receive buffer and data register.
// - Each serial output is ANDed with its software port output.
// - Enable pin driven only in three-wire mode, else left to general I/O.
// - Incoming clock and data lines are glitch filtered.
// - Receiving the last byte (stop enabled), no acknowledge is driven.
// - Bus clock runs at 62.5 kHz in every mode; a slave can stretch it in acknowledged modes.
// - Ninth clock per byte: transmitter releases data, acknowledging receiver pulls low.
// - Three-wire start is enable falling, stop enable rising, with clock high.
// - Shift-register mode: no start, stop or acknowledge, no clock stretching.
`default_nettype none
`include "serial_master_defs.svh"
module tri_protocol_serial_master
  import serial_master_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = `SCL_HALF_CYCLES,
  parameter int unsigned FILTER_LEN  = `FILTER_LEN
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [9:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output var  logic [31:0] READDATA,
  output var  logic        WAITREQUEST,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  input  wire logic        PORT_SCL,
  input  wire logic        PORT_SDA,
  input  wire logic        PORT_SEN,
  output var  logic        SCL_OUT,
  output var  logic        SCL_OE,
  output var  logic        SDA_OUT,
  output var  logic        SDA_OE,
  output var  logic        SEN_OUT,
  output var  logic        SEN_OE,
  output var  logic        VSYNC_IRQ_EN
);

  localparam logic [11:0] HALF_LAST = 12'(HALF_CYCLES - 1);

  // ----------------------------------------------------------------
  // input filtering
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;

  sync_glitch_filter #(.LEN(FILTER_LEN)) scl_filter (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .din     (SCL_IN),
    .dout    (scl_f)
  );

  sync_glitch_filter #(.LEN(FILTER_LEN)) sda_filter (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .din     (SDA_IN),
    .dout    (sda_f)
  );

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  mode_type    mode_r;
  mode_type    mode_nxt;
  logic        start_en_r;
  logic        start_en_nxt;
  logic        stop_en_r;
  logic        stop_en_nxt;
  logic        tx_r;
  logic        tx_nxt;
  logic        vsync_en_r;
  logic        vsync_en_nxt;

  state_type   state_r;
  logic        busy_r;
  logic        verify_r;
  logic        noack_r;
  logic [7:0]  shift_r;

  logic [7:0]  addr_idx;
  logic        capture;
  logic        wr_do;
  logic        wr_mode_do;
  logic        wr_status_do;
  logic        wr_data_do;
  logic        start_go;
  logic        ack_mode;
  logic        three_wire;

  assign addr_idx     = ADDRESS[9:2];
  assign capture      = (READ || WRITE) && wait_r;
  // a write lands on the edge where waitrequest is seen low
  assign wr_do        = WRITE && !wait_r && BYTEENABLE[0];
  assign wr_mode_do   = wr_do && (addr_idx == `IDX_MODE_CONTROL);
  assign wr_status_do = wr_do && (addr_idx == `IDX_XFER_STATUS);
  assign wr_data_do   = wr_do && (addr_idx == `IDX_SHIFT_DATA) && !busy_r;
  // zero in the busy position is ignored, so no abort path exists
  assign start_go     = wr_status_do && WRITEDATA[`ST_BUSY_BIT] && !busy_r
                        && (mode_r != MODE_OFF);
  assign ack_mode     = (mode_r == MODE_TWO_WIRE) || (mode_r == MODE_THREE_WIRE);
  assign three_wire   = (mode_r == MODE_THREE_WIRE);

  always_comb begin
    wait_nxt     = !capture;
    rdata_nxt    = rdata_r;
    mode_nxt     = mode_r;
    start_en_nxt = start_en_r;
    stop_en_nxt  = stop_en_r;
    tx_nxt       = tx_r;
    vsync_en_nxt = vsync_en_r;
    if (capture) begin
      rdata_nxt = `WORD_RST;
      if (READ && (addr_idx == `IDX_XFER_STATUS)) begin
        rdata_nxt[`ST_VERIFY_BIT] = verify_r;
        rdata_nxt[`ST_NOACK_BIT]  = noack_r;
        rdata_nxt[`ST_BUSY_BIT]   = busy_r;
      end else if (READ && (addr_idx == `IDX_SHIFT_DATA) && !busy_r) begin
        rdata_nxt[7:0] = shift_r;
      end
    end
    if (wr_mode_do) begin
      mode_nxt     = mode_type'(WRITEDATA[`MC_MODE_HI:`MC_MODE_LO]);
      start_en_nxt = WRITEDATA[`MC_START_BIT];
      stop_en_nxt  = WRITEDATA[`MC_STOP_BIT];
    end
    if (wr_status_do) begin
      vsync_en_nxt = WRITEDATA[`ST_VERIFY_BIT];
      if (!busy_r) begin
        tx_nxt = WRITEDATA[`ST_DIR_BIT];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wait_r     <= 1'b1;
      rdata_r    <= `WORD_RST;
      mode_r     <= MODE_OFF;
      start_en_r <= 1'b0;
      stop_en_r  <= 1'b0;
      tx_r       <= 1'b0;
      vsync_en_r <= 1'b0;
    end else begin
      wait_r     <= wait_nxt;
      rdata_r    <= rdata_nxt;
      mode_r     <= mode_nxt;
      start_en_r <= start_en_nxt;
      stop_en_r  <= stop_en_nxt;
      tx_r       <= tx_nxt;
      vsync_en_r <= vsync_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  state_type   state_nxt;
  logic [1:0]  ph_r;
  logic [1:0]  ph_nxt;
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic [3:0]  bit_r;
  logic [3:0]  bit_nxt;
  logic [7:0]  shift_nxt;
  line_type    hw_r;
  line_type    hw_nxt;
  logic        busy_nxt;
  logic        verify_nxt;
  logic        noack_nxt;
  logic        in_high;
  logic        cnt_run;
  logic        cnt_done;
  logic        dir_now;
  logic [3:0]  last_bit;

  assign in_high  = (state_r == S_HIGH) || ((state_r != S_LOW) && (ph_r == 2'h1));
  // high halves stall while a slave stretches the clock
  assign cnt_run  = !(in_high && ack_mode && !scl_f);
  assign cnt_done = cnt_run && (cnt_r == HALF_LAST);
  assign dir_now  = WRITEDATA[`ST_DIR_BIT];
  assign last_bit = ack_mode ? `ACK_BIT : `LAST_DATA_BIT;

  always_comb begin
    state_nxt  = state_r;
    ph_nxt     = ph_r;
    cnt_nxt    = cnt_r;
    bit_nxt    = bit_r;
    shift_nxt  = shift_r;
    hw_nxt     = hw_r;
    busy_nxt   = busy_r;
    verify_nxt = verify_r;
    noack_nxt  = noack_r;
    if (cnt_run) begin
      cnt_nxt = (cnt_r == HALF_LAST) ? `CNT_RST : cnt_r + 12'h001;
    end
    case (state_r)
      S_IDLE: begin
        cnt_nxt = `CNT_RST;
        if (wr_data_do) begin
          shift_nxt = WRITEDATA[7:0];
        end
        if (start_go) begin
          busy_nxt  = 1'b1;
          noack_nxt = 1'b0;
          bit_nxt   = `BIT_RST;
          ph_nxt    = `PH_RST;
          if (ack_mode && dir_now) begin
            verify_nxt = 1'b1;
          end
          if (ack_mode && start_en_r) begin
            state_nxt = S_START;
          end else begin
            state_nxt  = S_LOW;
            hw_nxt.scl = 1'b0;
            hw_nxt.sda = dir_now ? shift_r[`DATA_MSB] : 1'b1;
          end
        end
      end
      S_START: begin
        case (ph_r)
          2'h0: begin
            hw_nxt.sda = 1'b1;
            hw_nxt.serial_frame_enable_pin = 1'b1;
            if (cnt_done) begin
              ph_nxt     = 2'h1;
              hw_nxt.scl = 1'b1;
            end
          end
          2'h1: begin
            if (cnt_done) begin
              ph_nxt = 2'h2;
              if (three_wire) begin
                hw_nxt.serial_frame_enable_pin = 1'b0;
              end else begin
                hw_nxt.sda = 1'b0;
              end
            end
          end
          default: begin
            if (cnt_done) begin
              state_nxt  = S_LOW;
              hw_nxt.scl = 1'b0;
              hw_nxt.serial_frame_enable_pin = 1'b1;
              hw_nxt.sda = tx_r ? shift_r[`DATA_MSB] : 1'b1;
            end
          end
        endcase
      end
      S_LOW: begin
        if (cnt_done) begin
          state_nxt  = S_HIGH;
          hw_nxt.scl = 1'b1;
        end
      end
      S_HIGH: begin
        if (tx_r && ack_mode && (bit_r <= `LAST_DATA_BIT) && scl_f && (sda_f != hw_r.sda)) begin
          verify_nxt = 1'b0;
        end
        if (cnt_done) begin
          if (bit_r == `ACK_BIT) begin
            if (tx_r) begin
              noack_nxt = sda_f;
            end
          end else begin
            shift_nxt = {shift_r[6:0], sda_f};
          end
          if (bit_r == last_bit) begin
            if (ack_mode && stop_en_r) begin
              state_nxt  = S_STOP;
              ph_nxt     = `PH_RST;
              hw_nxt.scl = 1'b0;
              hw_nxt.sda = three_wire;
              hw_nxt.serial_frame_enable_pin = !three_wire;
            end else begin
              state_nxt  = S_IDLE;
              busy_nxt   = 1'b0;
              hw_nxt.sda = 1'b1;
              // acknowledged modes keep the clock low between bytes
              hw_nxt.scl = !ack_mode;
            end
          end else begin
            bit_nxt    = bit_r + 4'h1;
            state_nxt  = S_LOW;
            hw_nxt.scl = 1'b0;
            if (bit_r == `LAST_DATA_BIT) begin
              hw_nxt.sda = tx_r || stop_en_r;
            end else begin
              hw_nxt.sda = tx_r ? shift_nxt[`DATA_MSB] : 1'b1;
            end
          end
        end
      end
      S_STOP: begin
        case (ph_r)
          2'h0: begin
            if (cnt_done) begin
              ph_nxt     = 2'h1;
              hw_nxt.scl = 1'b1;
            end
          end
          2'h1: begin
            if (cnt_done) begin
              ph_nxt     = 2'h2;
              hw_nxt.sda = 1'b1;
              hw_nxt.serial_frame_enable_pin = 1'b1;
            end
          end
          default: begin
            if (cnt_done) begin
              state_nxt = S_IDLE;
              busy_nxt  = 1'b0;
            end
          end
        endcase
      end
      default: begin
        state_nxt = S_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r  <= S_IDLE;
      ph_r     <= `PH_RST;
      cnt_r    <= `CNT_RST;
      bit_r    <= `BIT_RST;
      shift_r  <= `BYTE_RST;
      hw_r     <= '1;
      busy_r   <= 1'b0;
      verify_r <= 1'b0;
      noack_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      ph_r     <= ph_nxt;
      cnt_r    <= cnt_nxt;
      bit_r    <= bit_nxt;
      shift_r  <= shift_nxt;
      hw_r     <= hw_nxt;
      busy_r   <= busy_nxt;
      verify_r <= verify_nxt;
      noack_r  <= noack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic     zero_r;
  line_type oe_nxt;
  line_type oe_r;

  // open drain: a pin is pulled only when the ANDed level is low
  always_comb begin
    oe_nxt.scl = !(hw_nxt.scl && PORT_SCL);
    oe_nxt.sda = !(hw_nxt.sda && PORT_SDA);
    oe_nxt.serial_frame_enable_pin = !((mode_nxt != MODE_THREE_WIRE || hw_nxt.serial_frame_enable_pin) && PORT_SEN);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      zero_r <= 1'b0;
      oe_r   <= '0;
    end else begin
      zero_r <= 1'b0;
      oe_r   <= oe_nxt;
    end
  end

  assign READDATA     = rdata_r;
  assign WAITREQUEST  = wait_r;
  assign SCL_OUT      = zero_r;
  assign SDA_OUT      = zero_r;
  assign SEN_OUT      = zero_r;
  assign SCL_OE       = oe_r.scl;
  assign SDA_OE       = oe_r.sda;
  assign SEN_OE       = oe_r.serial_frame_enable_pin;
  assign VSYNC_IRQ_EN = vsync_en_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  AST_RESET_CLEAR: assert property ($fell(SYS_RST) |-> !busy_r && mode_r == MODE_OFF && !tx_r)
    else $error("state not cleared by reset");
  AST_DATA_BLOCKED: assert property (capture && READ && busy_r && addr_idx == `IDX_SHIFT_DATA
    |=> READDATA == `WORD_RST)
    else $error("data register readable while busy");
  AST_START_NEEDS_MODE: assert property (start_go |-> mode_r != MODE_OFF ##1 busy_r)
    else $error("transfer started while disabled");
  AST_START_SKIPPED: assert property (start_go && !(ack_mode && start_en_r) |=> state_r == S_LOW)
    else $error("start generated when not enabled");
  AST_NOACK_CLEARED: assert property (start_go |=> !noack_r)
    else $error("no-ack not cleared at byte start");
  AST_VERIFY_SET: assert property (start_go && ack_mode && dir_now |=> verify_r)
    else $error("verify not set at transmit start");
  AST_NO_ABORT: assert property (busy_r && wr_status_do && !WRITEDATA[`ST_BUSY_BIT]
    && state_nxt != S_IDLE |=> busy_r)
    else $error("busy cleared by software");
  AST_SEN_FREE: assert property (mode_r != MODE_THREE_WIRE && $stable(mode_r)
    |=> SEN_OE == !$past(PORT_SEN))
    else $error("enable pin driven outside three-wire mode");
  AST_LAST_NO_ACK: assert property (state_r == S_HIGH && bit_r == `ACK_BIT && !tx_r && stop_en_r
    |-> hw_r.sda)
    else $error("acknowledge driven on last received byte");
  AST_HALF_PERIOD: assert property (state_r == S_LOW && !cnt_done
    |=> state_r == S_LOW && cnt_r == $past(cnt_r) + 12'h001)
    else $error("low half period length wrong");
  AST_LOW_FROM_ZERO: assert property (state_r != S_LOW ##1 state_r == S_LOW
    |-> cnt_r == `CNT_RST)
    else $error("low half period not counted from zero");

endmodule
`default_nettype wire

// >>> test/bus_slave_model.sv
// behavioural bus slave: acks, sends, stretches the clock and jams data on command
`default_nettype none
module bus_slave_model (
  input  wire logic       clk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       serial_frame_enable_pin,
  input  wire logic       send,
  input  wire logic       ack_en,
  input  wire logic       jam,
  input  wire logic       stretch,
  input  wire logic [7:0] tx_byte,
  output var  logic       scl_oe,
  output var  logic       sda_oe,
  output var  logic [7:0] rx_byte,
  output var  logic       ack_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q  = 1'b1;
  logic sda_q  = 1'b1;
  logic sen_q  = 1'b1;
  logic active = 1'b0;
  int   bitn   = -1;
  int   hold   = 0;
  // ----------------------------------------
  // framing: start/stop seen on data or enable line while clock high
  // ----------------------------------------
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    sen_q <= serial_frame_enable_pin;
    if (hold > 0) hold <= hold - 1;
    if (scl && scl_q && ((sda_q && !sda) || (sen_q && !serial_frame_enable_pin))) begin
      active <= 1'b1;
      bitn   <= -1;
    end else if (scl && scl_q && ((!sda_q && sda) || (!sen_q && serial_frame_enable_pin))) begin
      active <= 1'b0;
    end else if (active && scl_q && !scl) begin
      bitn <= bitn + 1;
      if (stretch) hold <= 20;
    end
    if (active && !scl_q && scl && bitn >= 0 && bitn < 8) rx_byte <= {rx_byte[6:0], sda};
    if (active && !scl_q && scl && bitn == 8) ack_level <= sda;
  end
  // holding the clock low only delays the master, never changes the data
  assign scl_oe = hold > 0;
  assign sda_oe = active && bitn >= 0 && ((bitn < 8 && ((send && !tx_byte[7-bitn]) || jam)) ||
                  (bitn == 8 && !send && ack_en));
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the three-protocol serial master
`default_nettype none
`include "serial_master_defs.svh"
module testbench;
  import serial_master_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [9:0]  ADDRESS = 10'h000;
  logic        READ = 1'b0;
  logic        WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0000_0000;
  logic [3:0]  BYTEENABLE = 4'hF;
  logic [31:0] READDATA;
  logic        WAITREQUEST;
  logic        PORT_SDA = 1'b1;
  logic        PORT_SEN = 1'b1;
  logic        SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, SEN_OUT, SEN_OE, VSYNC_IRQ_EN;
  logic        p_scl_oe, p_sda_oe, ack_level;
  logic        send = 1'b0, ack_en = 1'b1, jam = 1'b0, stretch = 1'b0;
  logic [7:0]  p_tx = 8'h00, p_rx, mon = 8'h00;
  logic        scl_q = 1'b1, sen_q = 1'b1;
  logic [31:0] rd;
  int          mismatches = 0, checks_done = 0, cycles = 0, sen_falls = 0;
  // open-drain wires with pull-ups
  wire logic scl = ~(SCL_OE | p_scl_oe);
  wire logic sda = ~(SDA_OE | p_sda_oe);
  wire logic serial_frame_enable_pin = ~SEN_OE;

  initial forever #12.5 CLK = ~CLK;

  tri_protocol_serial_master #(.HALF_CYCLES(8), .FILTER_LEN(3)) DUT (
    .CLK(CLK), .SYS_RST(SYS_RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .SCL_IN(scl), .SDA_IN(sda), .PORT_SCL(1'b1),
    .PORT_SDA(PORT_SDA), .PORT_SEN(PORT_SEN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SEN_OUT(SEN_OUT), .SEN_OE(SEN_OE),
    .VSYNC_IRQ_EN(VSYNC_IRQ_EN));

  bus_slave_model SLAVE (
    .clk(CLK), .scl(scl), .sda(sda), .serial_frame_enable_pin(serial_frame_enable_pin), .send(send), .ack_en(ack_en), .jam(jam),
    .stretch(stretch), .tx_byte(p_tx), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe),
    .rx_byte(p_rx), .ack_level(ack_level));

  // ----------------------------------------
  // wire monitor and hang guard
  // ----------------------------------------
  always @(posedge CLK) begin
    scl_q <= scl;
    sen_q <= serial_frame_enable_pin;
    if (!scl_q && scl) mon <= {mon[6:0], sda};
    if (sen_q && !serial_frame_enable_pin) sen_falls++;
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access; held until waitrequest is sampled low, then a gap cycle
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdata);
    ADDRESS   <= {idx, 2'b00};
    WRITEDATA <= {24'h000000, wd};
    WRITE     <= wr;
    READ      <= !wr;
    // only the cycle guard ends a wait that never answers
    do begin
      @(posedge CLK);
    end while (WAITREQUEST !== 1'b0);
    rdata = READDATA;
    WRITE <= 1'b0;
    READ  <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    chk(what, rd, {24'h000000, exp});
  endtask

  task automatic run(input logic [3:0] mc, input logic dir, input logic [7:0] d);
    sen_falls = 0;
    wr(`IDX_MODE_CONTROL, {4'h0, mc});
    if (dir) wr(`IDX_SHIFT_DATA, d);
    wr(`IDX_XFER_STATUS, {4'h0, dir, 3'b001});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, `IDX_XFER_STATUS, 8'h00, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    chk("busy clears", {31'h0, rd[0]}, 32'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (8) @(posedge CLK);
    rchk("mode after reset", `IDX_MODE_CONTROL, 8'h00);
    rchk("status after reset", `IDX_XFER_STATUS, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    wr(`IDX_XFER_STATUS, 8'h01);
    rchk("busy with mode off", `IDX_XFER_STATUS, 8'h00);
    wr(`IDX_XFER_STATUS, 8'h04);
    chk("vsync enable set", VSYNC_IRQ_EN, 1);
    wr(`IDX_XFER_STATUS, 8'h00);
    chk("vsync enable clear", VSYNC_IRQ_EN, 0);
    PORT_SDA <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("port and data low", SDA_OE, 1);
    PORT_SDA <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("port and data high", SDA_OE, 0);
    PORT_SEN <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("port and enable low", SEN_OE, 1);
    PORT_SEN <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("port and enable high", SEN_OE, 0);
    chk("drive levels", {29'h0, SCL_OUT, SDA_OUT, SEN_OUT}, 32'h0);
    // shift mode, start requested but ignored, stop kept clear
    run(4'b1001, 1'b1, 8'h5A);
    wait_idle();
    chk("shift wire byte", mon, 8'h5A);
    chk("shift enable pin", sen_falls, 0);
    rchk("shift readback", `IDX_SHIFT_DATA, 8'h5A);
    // two-wire transmit with a slave stretching the clock
    stretch <= 1'b1;
    run(4'b1110, 1'b1, 8'hA5);
    rchk("data while busy", `IDX_SHIFT_DATA, 8'h00);
    wr(`IDX_XFER_STATUS, 8'h08);
    rchk("status while busy", `IDX_XFER_STATUS, 8'h05);
    wait_idle();
    stretch <= 1'b0;
    chk("slave got byte", p_rx, 8'hA5);
    chk("two-wire enable pin", sen_falls, 0);
    rchk("acked tx status", `IDX_XFER_STATUS, 8'h04);
    ack_en <= 1'b0;
    run(4'b1110, 1'b1, 8'h3C);
    wait_idle();
    rchk("nack status", `IDX_XFER_STATUS, 8'h06);
    ack_en <= 1'b1;
    jam    <= 1'b1;
    run(4'b1110, 1'b1, 8'hFF);
    wait_idle();
    jam <= 1'b0;
    rchk("jammed status", `IDX_XFER_STATUS, 8'h00);
    rchk("jammed readback", `IDX_SHIFT_DATA, 8'h00);
    // two-wire receive: acked byte, then last byte with stop
    send <= 1'b1;
    p_tx <= 8'hC3;
    run(4'b1010, 1'b0, 8'h00);
    wait_idle();
    chk("master ack", ack_level, 0);
    rchk("rx byte", `IDX_SHIFT_DATA, 8'hC3);
    p_tx <= 8'h96;
    run(4'b1110, 1'b0, 8'h00);
    wait_idle();
    chk("no ack on last", ack_level, 1);
    rchk("last rx byte", `IDX_SHIFT_DATA, 8'h96);
    // three-wire transmit framed on the enable line
    send <= 1'b0;
    run(4'b1111, 1'b1, 8'h69);
    wait_idle();
    chk("three-wire byte", p_rx, 8'h69);
    chk("enable pulses", sen_falls, 2);
    rchk("three-wire status", `IDX_XFER_STATUS, 8'h04);
    report_and_stop();
  end
endmodule
`default_nettype wire
